/* File: core/swrc_pkg.sv */
// shared constants, types and reset tables of the sleep, watchdog and reset controller
package swrc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int TWDT_MS = 12;
	localparam int TPOR_MS = 20;
	// least times, so round up to whole cycles
	localparam int WDT_CYC = (TWDT_MS * CLK_HZ + 999) / 1000;
	localparam int POR_CYC = (TPOR_MS * CLK_HZ + 999) / 1000;
	// the crystal is the block clock, so crystal cycles are clock cycles
	localparam int XTAL_EXTRA = 18;
	localparam int CNT_W = 24;

	// ----------------------------------------------------------------
	// opcodes seen on the opcode register
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WDT = 8'h5F;
	localparam logic [7:0] OP_WDH = 8'h4F;
	localparam logic [7:0] OP_STOP = 8'h6F;
	localparam logic [7:0] OP_HALT = 8'h7F;
	localparam logic [15:0] START_VECTOR = 16'h000C;

	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] IX_OPCODE = 8'h00;
	localparam logic [7:0] IX_STATUS = 8'h01;
	localparam logic [7:0] IX_TIMER_MODE_CTRL = 8'hF1;
	localparam logic [7:0] IX_TIMER1_COUNT = 8'hF2;
	localparam logic [7:0] IX_TIMER1_PRESCALE = 8'hF3;
	localparam logic [7:0] IX_TIMER0_COUNT = 8'hF4;
	localparam logic [7:0] IX_TIMER0_PRESCALE = 8'hF5;
	localparam logic [7:0] IX_PORT_TWO_MODE = 8'hF6;
	localparam logic [7:0] IX_PORT_THREE_MODE = 8'hF7;
	localparam logic [7:0] IX_PORT_ZERO_ONE_MODE = 8'hF8;
	localparam logic [7:0] IX_IRQ_PRIORITY = 8'hF9;
	localparam logic [7:0] IX_IRQ_PENDING = 8'hFA;
	localparam logic [7:0] IX_IRQ_MASK = 8'hFB;
	localparam logic [7:0] IX_CPU_FLAGS = 8'hFC;
	localparam logic [7:0] IX_WORKING_BANK_POINTER = 8'hFD;
	localparam logic [7:0] IX_STACK_POINTER_LOW = 8'hFF;

	// field positions
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam int IRQ_LINE_D = 3;
	localparam int IMR_GLOBAL = 7;
	localparam logic [7:0] IRQ_LINES = 8'h0F;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {M_RUN, M_HALT, M_STOP, M_RESET} swrc_mode_t;
	typedef enum logic [1:0] {C_POWER, C_WDOG, C_LOWV, C_WAKE} swrc_cause_t;
	typedef logic [15:0][7:0] swrc_regs_t;

	// bits that take a defined value on reset
	function automatic logic [7:0] swrc_rst_mask(input logic [7:0] ix);
		case (ix)
			IX_TIMER_MODE_CTRL, IX_PORT_TWO_MODE, IX_WORKING_BANK_POINTER,
			IX_STACK_POINTER_LOW: swrc_rst_mask = 8'hFF;
			IX_TIMER1_PRESCALE, IX_PORT_THREE_MODE: swrc_rst_mask = 8'h03;
			IX_TIMER0_PRESCALE: swrc_rst_mask = 8'h01;
			IX_PORT_ZERO_ONE_MODE: swrc_rst_mask = 8'h13;
			IX_IRQ_PENDING: swrc_rst_mask = 8'h3F;
			IX_IRQ_MASK: swrc_rst_mask = 8'h80;
			default: swrc_rst_mask = 8'h00;
		endcase
	endfunction : swrc_rst_mask

	function automatic logic [7:0] swrc_rst_val(input logic [7:0] ix);
		case (ix)
			IX_PORT_TWO_MODE: swrc_rst_val = 8'hFF;
			IX_PORT_ZERO_ONE_MODE: swrc_rst_val = 8'h01;
			default: swrc_rst_val = 8'h00;
		endcase
	endfunction : swrc_rst_val

	function automatic logic swrc_is_port_mode(input logic [7:0] ix);
		swrc_is_port_mode = (ix == IX_PORT_TWO_MODE) || (ix == IX_PORT_THREE_MODE) ||
			(ix == IX_PORT_ZERO_ONE_MODE);
	endfunction : swrc_is_port_mode

	// ----------------------------------------------------------------
	// bus decode helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] swrc_idx(input logic [11:0] addr);
		swrc_idx = addr[9:2];
	endfunction : swrc_idx

	function automatic logic swrc_mapped(input logic [11:0] addr);
		logic [7:0] ix;
		ix = addr[9:2];
		swrc_mapped = (addr[11:10] == 2'h0) && (ix == IX_OPCODE || ix == IX_STATUS ||
			(ix >= IX_TIMER_MODE_CTRL && ix != 8'hFE));
	endfunction : swrc_mapped

endpackage : swrc_pkg

/* File: core/swrc_wdog.sv */
// watchdog counter with software, halt-keepalive and permanent enables
`timescale 1ns/1ps
module swrc_wdog import swrc_pkg::*; #(
	parameter int WDT_CYCLES = WDT_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sys_clear,
	input wire logic perm_opt,
	input wire logic op_wdt,
	input wire logic op_wdh,
	input wire logic in_halt,
	input wire logic in_stop,
	output logic timeout,
	output logic enabled,
	output logic halt_run
);

	typedef struct packed {
		logic en;
		logic hrun;
		logic tout;
		logic [CNT_W-1:0] cnt;
	} swrc_wd_t;

	swrc_wd_t s;
	swrc_wd_t next_s;
	logic run;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.tout = 1'b0;
		run = 1'b0;
		if (sys_clear) begin
			next_s.en = perm_opt;
			next_s.hrun = 1'b0;
			next_s.cnt = '0;
		end else begin
			if (op_wdt) begin
				next_s.en = 1'b1;
				next_s.cnt = '0;
			end
			if (op_wdh && s.en) begin
				next_s.hrun = 1'b1;
			end
			if (perm_opt) begin
				next_s.en = 1'b1;
			end
			// software dog pauses in stop, and in halt unless kept alive
			run = s.en && (perm_opt || (!in_stop && (!in_halt || s.hrun)));
			if (run && !op_wdt) begin
				if (s.cnt == CNT_W'(WDT_CYCLES - 1)) begin
					next_s.tout = 1'b1;
					next_s.cnt = '0;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign timeout = s.tout;
	assign enabled = s.en;
	assign halt_run = s.hrun;

	// once on, only a reset turns the dog off
	chk_wdt_stays_on: assert property (@(posedge clk) disable iff (!rst_b)
		s.en && !sys_clear |=> s.en) else $error("watchdog dropped while enabled");

endmodule : swrc_wdog

/* File: core/swrc_top.sv */
// sleep modes, watchdog and reset control with an AXI4-Lite register slave
//
// What this block does
// - reset clears low six pending bits, line d rising
// - wake-pin stop recovery keeps port mode registers
// - other resets restore port mode defaults
// - halt gates cpu clock, oscillator and timers run
// - halt ends only on enabled pending interrupt or a reset
// - after service, resume past the halt
// - stop kills internal clock and oscillator
// - low wake pin resets; start at 000C
// - wake pin sensed even when driven output
// - first watchdog op enables, later ones clear
// - enabled watchdog cannot be stopped
// - timeout gives power-on delay plus 18 cycles
// - watchdog op sets zero, clears sign, overflow
// - software watchdog pauses in stop
// - halt keepalive op keeps dog counting in halt
// - keepalive op ignored until watchdog enabled
// - permanent option: always on, runs everywhere
// - low supply detector forces reset
// - reduced emission: clocks equal oscillator
// - latch disable option turns all latches off
// - test disable option refuses programming modes
// - standard mode: clocks are oscillator over two
// - watchdog timeout at least 12 ms
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module swrc_top import swrc_pkg::*; #(
	parameter int POR_CYCLES = POR_CYC,
	parameter int WDT_CYCLES = WDT_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] ext_int_lines,
	input wire logic stop_wake_pin,
	input wire logic low_voltage_det,
	input wire logic opt_reduced_emission,
	input wire logic opt_auto_latch_dis,
	input wire logic opt_perm_wdog,
	input wire logic opt_test_dis,
	input wire logic program_mode_select,
	output logic cpu_clk_en,
	output logic osc_en,
	output logic sys_tick,
	output logic timer_clock,
	output logic sys_reset,
	output logic halt_resume,
	output logic [15:0] start_vector,
	output logic auto_latch_en,
	output logic prog_mode_grant,
	output logic watchdog_on
);

	typedef struct packed {
		swrc_mode_t mode;
		swrc_cause_t cause;
		logic [CNT_W-1:0] rcnt;
		swrc_regs_t regs;
		logic [3:0] prev_lines;
		logic div;
		logic [11:0] waddr;
		logic [7:0] wbyte;
		logic wlow;
		logic aw_ok;
		logic w_ok;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rbyte;
		logic cpu_clk_en;
		logic osc_en;
		logic sys_tick;
		logic timer_clock;
		logic sys_reset;
		logic halt_resume;
		logic [15:0] start_vector;
		logic auto_latch_en;
		logic prog_grant;
	} swrc_state_t;

	swrc_state_t s;
	swrc_state_t next_s;
	logic op_wdt;
	logic op_wdh;
	logic wd_tout;
	logic wd_en;
	logic wd_hrun;
	logic [3:0] edges;
	logic [7:0] ix;
	logic [7:0] rx;
	logic [7:0] live_irq;
	logic [CNT_W-1:0] rlim;
	logic tick;

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	swrc_wdog #(.WDT_CYCLES(WDT_CYCLES)) u_wdog (
		.clk(clk),
		.rst_b(rst_b),
		.sys_clear(s.mode == M_RESET),
		.perm_opt(opt_perm_wdog),
		.op_wdt(op_wdt),
		.op_wdh(op_wdh),
		.in_halt(s.mode == M_HALT),
		.in_stop(s.mode == M_STOP),
		.timeout(wd_tout),
		.enabled(wd_en),
		.halt_run(wd_hrun)
	);

	// ----------------------------------------------------------------
	// next state: bus, interrupt edges, mode sequencer, clock enables
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.halt_resume = 1'b0;
		op_wdt = 1'b0;
		op_wdh = 1'b0;
		ix = swrc_idx(s.waddr);
		rx = swrc_idx(s_axi_araddr);
		// bus write: address and data may arrive in either order
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_ok = 1'b1;
			next_s.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_ok = 1'b1;
			next_s.wbyte = s_axi_wdata[7:0];
			next_s.wlow = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_ok && s.w_ok && !s.bvalid) begin
			next_s.aw_ok = 1'b0;
			next_s.w_ok = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = swrc_mapped(s.waddr) ? RESP_OKAY : RESP_SLVERR;
			// writes during reset are dropped, the defaults must win
			if (swrc_mapped(s.waddr) && s.wlow && s.mode != M_RESET) begin
				if (ix == IX_OPCODE) begin
					if (s.mode == M_RUN) begin
						case (s.wbyte)
							OP_WDT: begin
								op_wdt = 1'b1;
								next_s.regs[IX_CPU_FLAGS[3:0]][FLAG_Z] = 1'b1;
								next_s.regs[IX_CPU_FLAGS[3:0]][FLAG_S] = 1'b0;
								next_s.regs[IX_CPU_FLAGS[3:0]][FLAG_V] = 1'b0;
							end
							OP_WDH: op_wdh = 1'b1;
							OP_STOP: next_s.mode = M_STOP;
							OP_HALT: next_s.mode = M_HALT;
							default: ;
						endcase
					end
				end else if (ix != IX_STATUS) begin
					next_s.regs[ix[3:0]] = s.wbyte;
				end
			end
		end
		// bus read; write-only registers read as zero
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = swrc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			next_s.rbyte = 8'h00;
			if (swrc_mapped(s_axi_araddr)) begin
				case (rx)
					IX_STATUS: next_s.rbyte = {2'h0, s.cause, wd_hrun, wd_en, s.mode};
					IX_OPCODE, IX_TIMER1_PRESCALE, IX_TIMER0_PRESCALE, IX_PORT_TWO_MODE,
					IX_PORT_THREE_MODE, IX_PORT_ZERO_ONE_MODE, IX_IRQ_PRIORITY: ;
					default: next_s.rbyte = s.regs[rx[3:0]];
				endcase
			end
		end
		// lines a..c request on falling edges, line d on rising
		edges = ~ext_int_lines & s.prev_lines;
		edges[IRQ_LINE_D] = ext_int_lines[IRQ_LINE_D] & ~s.prev_lines[IRQ_LINE_D];
		next_s.prev_lines = ext_int_lines;
		// a hardware set lands after the software write, so the set wins
		next_s.regs[IX_IRQ_PENDING[3:0]] = next_s.regs[IX_IRQ_PENDING[3:0]] | {4'h0, edges};
		live_irq = s.regs[IX_IRQ_PENDING[3:0]] & s.regs[IX_IRQ_MASK[3:0]] & IRQ_LINES;
		// reset length follows the cause
		case (s.cause)
			C_WAKE: rlim = CNT_W'(XTAL_EXTRA);
			C_WDOG: rlim = CNT_W'(POR_CYCLES + XTAL_EXTRA);
			default: rlim = CNT_W'(POR_CYCLES);
		endcase
		// mode sequencer
		case (s.mode)
			M_RESET: begin
				if (s.rcnt >= rlim - 1'b1) begin
					next_s.mode = M_RUN;
					next_s.rcnt = '0;
					next_s.start_vector = START_VECTOR;
				end else begin
					next_s.rcnt = s.rcnt + 1'b1;
				end
			end
			M_HALT: begin
				// only an enabled request wakes, the cpu then services it
				if (s.regs[IX_IRQ_MASK[3:0]][IMR_GLOBAL] && live_irq != 8'h00) begin
					next_s.mode = M_RUN;
					next_s.halt_resume = 1'b1;
				end
			end
			M_STOP: begin
				// pin sensed raw, whatever its port direction
				if (!stop_wake_pin) begin
					next_s.mode = M_RESET;
					next_s.cause = C_WAKE;
					next_s.rcnt = '0;
				end
			end
			M_RUN: ;
			default: next_s.mode = M_RESET;
		endcase
		if (wd_tout) begin
			next_s.mode = M_RESET;
			next_s.cause = C_WDOG;
			next_s.rcnt = '0;
		end
		// supply below threshold holds reset and restarts its delay
		if (low_voltage_det) begin
			next_s.mode = M_RESET;
			next_s.cause = C_LOWV;
			next_s.rcnt = '0;
		end
		// defaults are driven every reset cycle so late edges cannot stick
		if (s.mode == M_RESET) begin
			for (int i = 0; i < 16; i++) begin
				if (!(s.cause == C_WAKE && swrc_is_port_mode(8'hF0 | 8'(i)))) begin
					next_s.regs[i] = (s.regs[i] & ~swrc_rst_mask(8'hF0 | 8'(i))) |
						swrc_rst_val(8'hF0 | 8'(i));
				end
			end
		end
		// clock enables: divider stops with the oscillator
		next_s.div = (next_s.mode == M_STOP) ? 1'b0 : ~s.div;
		tick = opt_reduced_emission ? 1'b1 : ~s.div;
		next_s.cpu_clk_en = (next_s.mode == M_RUN);
		next_s.osc_en = (next_s.mode != M_STOP);
		next_s.sys_tick = (next_s.mode == M_RUN) && tick;
		next_s.timer_clock = (next_s.mode == M_RUN || next_s.mode == M_HALT) && tick;
		next_s.sys_reset = (next_s.mode == M_RESET);
		next_s.auto_latch_en = !opt_auto_latch_dis;
		next_s.prog_grant = program_mode_select && !opt_test_dis;
		next_s.awready = !next_s.aw_ok && !next_s.bvalid;
		next_s.wready = !next_s.w_ok && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	// ----------------------------------------------------------------
	// state register, power-on enters the reset sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
			s.mode <= M_RESET;
			s.cause <= C_POWER;
			s.sys_reset <= 1'b1;
			s.osc_en <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = {24'h000000, s.rbyte};
	assign cpu_clk_en = s.cpu_clk_en;
	assign osc_en = s.osc_en;
	assign sys_tick = s.sys_tick;
	assign timer_clock = s.timer_clock;
	assign sys_reset = s.sys_reset;
	assign halt_resume = s.halt_resume;
	assign start_vector = s.start_vector;
	assign auto_latch_en = s.auto_latch_en;
	assign prog_mode_grant = s.prog_grant;
	assign watchdog_on = wd_en;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_irq_reset_clear: assert property (@(posedge clk) disable iff (!rst_b)
		s.mode == M_RESET && $past(s.mode) == M_RESET |->
		s.regs[IX_IRQ_PENDING[3:0]][5:0] == 6'h00) else $error("pending not cleared");
	chk_port_keep_wake: assert property (@(posedge clk) disable iff (!rst_b)
		s.mode == M_RESET && s.cause == C_WAKE |=> $stable(s.regs[IX_PORT_TWO_MODE[3:0]]))
		else $error("port mode changed on wake");
	chk_port_default: assert property (@(posedge clk) disable iff (!rst_b)
		s.mode == M_RESET && s.cause != C_WAKE |=> s.regs[IX_PORT_TWO_MODE[3:0]] == 8'hFF)
		else $error("port two mode not all inputs");
	chk_halt_clocks: assert property (@(posedge clk) disable iff (!rst_b)
		s.mode == M_HALT |-> !cpu_clk_en && osc_en) else $error("halt clock gating wrong");
	chk_stop_clocks: assert property (@(posedge clk) disable iff (!rst_b)
		s.mode == M_STOP |-> !osc_en && !cpu_clk_en) else $error("stop left clocks on");
	chk_halt_hold: assert property (@(posedge clk) disable iff (!rst_b)
		s.mode == M_HALT && live_irq == 8'h00 && !wd_tout && !low_voltage_det |=>
		s.mode == M_HALT) else $error("halt left without request");
	chk_wake_reset: assert property (@(posedge clk) disable iff (!rst_b)
		s.mode == M_STOP && !stop_wake_pin && !wd_tout && !low_voltage_det |=>
		s.mode == M_RESET ##[1:30] start_vector == START_VECTOR && s.mode == M_RUN)
		else $error("wake pin did not recover");
	chk_emission_tick: assert property (@(posedge clk) disable iff (!rst_b)
		opt_reduced_emission && $past(opt_reduced_emission) && cpu_clk_en |-> sys_tick)
		else $error("reduced emission clock divided");
	chk_lowv_reset: assert property (@(posedge clk) disable iff (!rst_b)
		low_voltage_det |=> sys_reset [*2]) else $error("low supply without reset");

endmodule : swrc_top

/* File: dv/sleep_watchdog_reset_ctrl_tb.sv */
// self-checking bench of the sleep, watchdog and reset controller
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module sleep_watchdog_reset_ctrl_tb import swrc_pkg::*;;
	// short counts keep the run brief
	localparam int PC = 40;
	localparam int WC = 60;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} swrc_note_t;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [3:0] ext_int_lines = 4'h7;
	logic stop_wake_pin = 1, low_voltage_det = 0, program_mode_select = 0;
	logic opt_reduced_emission = 0, opt_auto_latch_dis = 0, opt_perm_wdog = 0, opt_test_dis = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, wexp;
	logic [31:0] s_axi_rdata;
	logic cpu_clk_en, osc_en, sys_tick, timer_clock, sys_reset, halt_resume;
	logic auto_latch_en, prog_mode_grant, watchdog_on;
	logic [15:0] start_vector;
	swrc_note_t note;
	swrc_note_t rq[$];
	logic [1:0] wq[$];
	int bad_count = 0;
	int cmp_count = 0;
	integer seed = 32'hd3766516;

	swrc_top #(.POR_CYCLES(PC), .WDT_CYCLES(WC)) dut (.clk, .rst_b,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ext_int_lines, .stop_wake_pin, .low_voltage_det,
		.opt_reduced_emission, .opt_auto_latch_dis, .opt_perm_wdog, .opt_test_dis,
		.program_mode_select, .cpu_clk_en, .osc_en, .sys_tick, .timer_clock, .sys_reset,
		.halt_resume, .start_vector, .auto_latch_en, .prog_mode_grant, .watchdog_on);

	always #50 clk = ~clk;

	// ----------------------------------------------------------------
	// bus tasks, each waits for the slave's own answer
	// ----------------------------------------------------------------
	function automatic logic [11:0] ad(input logic [7:0] ix);
		ad = {2'h0, ix, 2'h0};
	endfunction : ad

	task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] r);
		wq.push_back(r);
		@(posedge clk);
		s_axi_awaddr <= ad(ix);
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no cycle count assumed, a hang is left to the run watchdog
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ix, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r);
		rq.push_back('{d, m, r});
		@(posedge clk);
		s_axi_araddr <= ad(ix);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	// bounded wait for the reset output to reach a level
	task automatic wait_rst(input logic v, input int lim, output int n);
		n = 0;
		while (sys_reset !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) bad_count++;
	endtask : wait_rst

	task automatic ticks(input int len, output int c);
		c = 0;
		repeat (len) begin
			@(posedge clk);
			if (timer_clock === 1'b1) c++;
		end
	endtask : ticks

	task automatic hard_reset();
		int n;
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		wait_rst(1'b0, PC + 10, n);
		`CHK(n > PC - 3, 1'b1)
		`CHK(start_vector, START_VECTOR)
	endtask : hard_reset

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// response watcher, oldest note first
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			note = rq.pop_front();
			`CHK(s_axi_rdata & note.m, note.d)
			`CHK(s_axi_rresp, note.r)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			wexp = wq.pop_front();
			`CHK(s_axi_bresp, wexp)
		end
	end

	// cut a hang short, the whole run needs well under this
	initial begin
		#2_000_000;
		bad_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n, c;
		logic [31:0] d;
		hard_reset();
		rd(IX_IRQ_PENDING, 32'h0, 32'h3F, RESP_OKAY);
		rd(IX_STACK_POINTER_LOW, 32'h0, 32'hFF, RESP_OKAY);
		rd(IX_WORKING_BANK_POINTER, 32'h0, 32'hFF, RESP_OKAY);
		rd(IX_TIMER_MODE_CTRL, 32'h0, 32'hFF, RESP_OKAY);
		rd(IX_IRQ_MASK, 32'h0, 32'h80, RESP_OKAY);
		// line d requests on a rising edge
		@(posedge clk) ext_int_lines <= 4'hF;
		rd(IX_IRQ_PENDING, 32'h8, 32'h8, RESP_OKAY);
		rd(8'hFE, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		wr(8'hFE, 8'h55, RESP_SLVERR);
		rd(IX_PORT_TWO_MODE, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
		d = $random(seed);
		wr(IX_STACK_POINTER_LOW, d[7:0], RESP_OKAY);
		rd(IX_STACK_POINTER_LOW, {24'h0, d[7:0]}, 32'hFF, RESP_OKAY);
		// low lane strobe off: the register must keep its value
		s_axi_wstrb <= 4'h0;
		wr(IX_STACK_POINTER_LOW, ~d[7:0], RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(IX_STACK_POINTER_LOW, {24'h0, d[7:0]}, 32'hFF, RESP_OKAY);
		// flags start opposite to what the watchdog op leaves
		wr(IX_CPU_FLAGS, 8'h30, RESP_OKAY);
		wr(IX_OPCODE, OP_WDT, RESP_OKAY);
		rd(IX_CPU_FLAGS, 32'h40, 32'h70, RESP_OKAY);
		rd(IX_STATUS, 32'h4, 32'h4, RESP_OKAY);
		// halt without keepalive: dog pauses, timers run
		wr(IX_IRQ_MASK, 8'h81, RESP_OKAY);
		wr(IX_OPCODE, 8'hFF, RESP_OKAY);
		wr(IX_OPCODE, OP_HALT, RESP_OKAY);
		`CHK(cpu_clk_en, 1'b0)
		`CHK(osc_en, 1'b1)
		ticks(20, c);
		`CHK(c, 10)
		`CHK(sys_tick, 1'b0)
		repeat (WC + 20) @(posedge clk);
		`CHK(sys_reset, 1'b0)
		`CHK(cpu_clk_en, 1'b0)
		ext_int_lines <= 4'hE;
		n = 0;
		while (halt_resume !== 1'b1 && n < 6) begin
			@(posedge clk);
			n++;
		end
		`CHK(n < 6, 1'b1)
		@(posedge clk) ext_int_lines <= 4'hF;
		`CHK(cpu_clk_en, 1'b1)
		// refresh keeps the dog quiet, then let it bite
		wr(IX_OPCODE, OP_WDT, RESP_OKAY);
		repeat (3) begin
			repeat (40) @(posedge clk);
			wr(IX_OPCODE, OP_WDT, RESP_OKAY);
		end
		`CHK(sys_reset, 1'b0)
		wait_rst(1'b1, WC + 10, n);
		`CHK(n >= WC - 5, 1'b1)
		wait_rst(1'b0, PC + 30, n);
		`CHK(n >= PC + 15, 1'b1)
		rd(IX_STATUS, 32'h10, 32'h34, RESP_OKAY);
		// keepalive ignored until enabled, then dog runs in halt
		wr(IX_OPCODE, OP_WDH, RESP_OKAY);
		rd(IX_STATUS, 32'h0, 32'h8, RESP_OKAY);
		wr(IX_OPCODE, OP_WDT, RESP_OKAY);
		wr(IX_OPCODE, OP_WDH, RESP_OKAY);
		rd(IX_STATUS, 32'h8, 32'h8, RESP_OKAY);
		wr(IX_OPCODE, 8'hFF, RESP_OKAY);
		wr(IX_OPCODE, OP_HALT, RESP_OKAY);
		wait_rst(1'b1, WC + 10, n);
		wait_rst(1'b0, PC + 30, n);
		// stop: clocks die, software dog pauses, wake pin recovers
		// wake pin set as output so the kept port mode differs from its default
		wr(IX_PORT_TWO_MODE, {1'b0, d[6:0]}, RESP_OKAY);
		wr(IX_OPCODE, OP_WDT, RESP_OKAY);
		wr(IX_OPCODE, 8'hFF, RESP_OKAY);
		wr(IX_OPCODE, OP_STOP, RESP_OKAY);
		`CHK(osc_en, 1'b0)
		ticks(WC + 20, c);
		`CHK(c, 0)
		`CHK(sys_reset, 1'b0)
		stop_wake_pin <= 1'b0;
		wait_rst(1'b1, 5, n);
		stop_wake_pin <= 1'b1;
		wait_rst(1'b0, 30, n);
		`CHK(n >= 15, 1'b1)
		`CHK(start_vector, START_VECTOR)
		rd(IX_STATUS, 32'h30, 32'h30, RESP_OKAY);
		// low supply forces a reset
		low_voltage_det <= 1'b1;
		wait_rst(1'b1, 5, n);
		repeat (10) @(posedge clk);
		low_voltage_det <= 1'b0;
		wait_rst(1'b0, PC + 10, n);
		rd(IX_STATUS, 32'h20, 32'h30, RESP_OKAY);
		// reduced emission drops the divide by two
		opt_reduced_emission <= 1'b1;
		ticks(4, c);
		ticks(20, c);
		`CHK(c, 20)
		`CHK(sys_tick, 1'b1)
		opt_reduced_emission <= 1'b0;
		program_mode_select <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			{opt_auto_latch_dis, opt_test_dis} <= i[1:0];
			repeat (3) @(posedge clk);
			`CHK(auto_latch_en, !i[1])
			`CHK(prog_mode_grant, !i[0])
		end
		// permanent dog: on from reset, runs in stop too
		opt_perm_wdog <= 1'b1;
		hard_reset();
		`CHK(watchdog_on, 1'b1)
		wr(IX_OPCODE, 8'hFF, RESP_OKAY);
		wr(IX_OPCODE, OP_STOP, RESP_OKAY);
		wait_rst(1'b1, WC + 10, n);
		opt_perm_wdog <= 1'b0;
		hard_reset();
		summarize();
	end
endmodule : sleep_watchdog_reset_ctrl_tb
